// >>> rtl/ing_guard.sv
// Interrupt acceptance, NMI guard, write protect and low-power control
`timescale 1ns/1ps
module ing_guard (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Register port
   input wire ing_pkg::ing_bus_s regReq,
   output logic [ing_pkg::DW-1:0] regRdata,
   // Request sources
   input wire logic [ing_pkg::NSRC-1:0] srcA,
   input wire logic [ing_pkg::NSRC-1:0] srcB,
   input wire logic nmiPin_b,
   // CPU side
   input wire logic intAck,
   input wire logic nmiAck,
   input wire logic waitEnter,
   output logic intReq,
   output ing_pkg::ing_vec_s intVec,
   output logic nmiReq,
   output logic cpuHalt,
   // Clock and power control, then the two stack pointers
   output logic cpuClkEn,
   output logic periphClkEn,
   output logic subPeriphClkEn,
   output logic onChipClkSel,
   output logic [ing_pkg::DW-1:0] userSp,
   output logic [ing_pkg::DW-1:0] intSp
);
   // Address match, used by the single-register write decodes and the vector read strobe, not by the ICR block or the read data mux
   function automatic logic hit(input logic [ing_pkg::AW-1:0] a,
                                input logic [ing_pkg::AW-1:0] b);
      hit = a == b;
   endfunction

   ing_pkg::ing_icr_s [ing_pkg::NSRC-1:0] icr_r;
   ing_pkg::ing_icr_s wIcr;
   ing_pkg::ing_vec_s vec_r;
   ing_pkg::ing_vec_s vecNxt;
   ing_pkg::ing_pwr_e pwr_r;
   ing_pkg::ing_pwr_e pwr_nxt;
   logic [ing_pkg::NSRC-1:0] srcSel_r;
   logic [ing_pkg::NSRC-1:0] effPrev_r;
   logic [ing_pkg::NSRC-1:0] srcLvl;
   logic [ing_pkg::NSRC-1:0] eff;
   logic [ing_pkg::NSRC-1:0] hwSet;
   logic [ing_pkg::NSRC-1:0] icrWr;
   logic [ing_pkg::NSRC-1:0] pendClr;
   logic [ing_pkg::NSRC-1:0] pendVec;
   logic [ing_pkg::NDEB-1:0] debIn;
   logic [ing_pkg::NDEB-1:0] debOut;
   logic [ing_pkg::NDEB-1:0][ing_pkg::DEB_W-1:0] debVal;
   logic [ing_pkg::DEB_W-1:0] nDeb_r;
   logic [ing_pkg::DEB_W-1:0] e5Deb_r;
   logic [ing_pkg::DW-1:0] usp_r;
   logic [ing_pkg::DW-1:0] isp_r;
   logic [ing_pkg::DW-1:0] rdata_r;
   logic [ing_pkg::DW-1:0] rdNxt;
   logic nmiEn_r;
   logic unlock_r;
   logic wpcs_r;
   logic mainClk_r;
   logic nmiArmPrev_r;
   logic nmiPend_r;
   logic nmiStall_r;
   logic uspSet_r;
   logic ispSet_r;
   logic spRdy_r;
   logic intReq_r;
   logic anyNxt;
   logic icrBlk;
   logic modeWr;
   logic protWr;
   logic vecRd;
   logic clrHi;
   logic pinLow;
   logic nmiArm;
   logic stopBlk;
   logic stopReq;
   logic stopBit;
   logic wake;

   // ========================================
   // Register decode
   assign icrBlk = regReq.addr[ing_pkg::AW-1:ing_pkg::IDXW]
                   == ing_pkg::ADDR_ICR0[ing_pkg::AW-1:ing_pkg::IDXW];
   assign modeWr = regReq.wr && hit(regReq.addr, ing_pkg::ADDR_MODE);
   assign protWr = regReq.wr && hit(regReq.addr, ing_pkg::ADDR_PROT);
   assign vecRd = regReq.rd && hit(regReq.addr, ing_pkg::ADDR_VEC);
   assign wIcr = regReq.wdata[ing_pkg::ICR_W-1:0];
   // stray vector read acts the same
   assign clrHi = (intAck || vecRd) && intReq_r;

   // ========================================
   // Debounce of the NMI pin and request five
   assign debIn[ing_pkg::DEB_NMI] = nmiPin_b;
   assign debIn[ing_pkg::DEB_EXT5] = srcLvl[ing_pkg::EXT5_IDX];
   assign debVal[ing_pkg::DEB_NMI] = nDeb_r;
   assign debVal[ing_pkg::DEB_EXT5] = e5Deb_r;

   for (genvar d = 0; d < ing_pkg::NDEB; d++) begin : g_deb
      ing_debounce u_deb (
         .clk(clk),
         .rst_b(rst_b),
         .pinIn(debIn[d]),
         .filtVal(debVal[d]),
         .pinOut(debOut[d])
      );
   end

   // ========================================
   // Per-source request flags
   for (genvar i = 0; i < ing_pkg::NSRC; i++) begin : g_src
      // Source select, then debounce for request five
      assign srcLvl[i] = srcSel_r[i] ? srcB[i] : srcA[i];
      // polarity or select change may set
      assign eff[i] = ~((i == ing_pkg::EXT5_IDX) ? debOut[ing_pkg::DEB_EXT5] : srcLvl[i])
                      ^ icr_r[i].trigger_polarity_bit;
      assign hwSet[i] = eff[i] & ~effPrev_r[i];
      assign icrWr[i] = regReq.wr && icrBlk
                        && (regReq.addr[ing_pkg::IDXW-1:0] == ing_pkg::IDXW'(i));
      // writing zero or accepting this vector clears
      assign pendClr[i] = (clrHi && (vec_r.num == ing_pkg::IDXW'(i)))
                          || (icrWr[i] && !wIcr.pend);
      assign pendVec[i] = icr_r[i].pend;

      // Control fields and pending flag
      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            icr_r[i] <= ing_pkg::ICR_RST;
            effPrev_r[i] <= 1'b0;
         end else begin
            if (icrWr[i]) begin
               icr_r[i].trigger_polarity_bit <= wIcr.trigger_polarity_bit;
               icr_r[i].level <= wIcr.level;
            end
            icr_r[i].pend <= hwSet[i] | (icr_r[i].pend & ~pendClr[i]);
            effPrev_r[i] <= eff[i];
         end
      end

      AST_PEND_SET: assert property (@(posedge clk) disable iff (!rst_b)
         hwSet[i] |=> pendVec[i])
         else $error("request edge lost its pending flag");
   end

   // ========================================
   // Highest enabled request, ties to the lower number
   always_comb begin
      anyNxt = 1'b0;
      vecNxt = ing_pkg::VEC_RST;
      for (int i = 0; i < ing_pkg::NSRC; i++) begin
         if (pendVec[i] && (icr_r[i].level != ing_pkg::LVL_OFF)
             && (!anyNxt || (icr_r[i].level > vecNxt.level))) begin
            anyNxt = 1'b1;
            vecNxt.num = ing_pkg::IDXW'(i);
            vecNxt.level = icr_r[i].level;
         end
      end
   end

   // Registered request toward the CPU
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         intReq_r <= 1'b0;
         vec_r <= ing_pkg::VEC_RST;
      end else begin
         // held off until both pointers loaded
         intReq_r <= anyNxt && spRdy_r;
         vec_r <= vecNxt;
      end
   end

   assign intReq = intReq_r;
   assign intVec = vec_r;

   // ========================================
   // Stack pointers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         usp_r <= ing_pkg::SP_RST;
         isp_r <= ing_pkg::SP_RST;
         uspSet_r <= 1'b0;
         ispSet_r <= 1'b0;
         spRdy_r <= 1'b0;
      end else begin
         if (regReq.wr && hit(regReq.addr, ing_pkg::ADDR_USP)) begin
            usp_r <= regReq.wdata;
            uspSet_r <= 1'b1;
         end
         if (regReq.wr && hit(regReq.addr, ing_pkg::ADDR_ISP)) begin
            isp_r <= regReq.wdata;
            ispSet_r <= 1'b1;
         end
         spRdy_r <= uspSet_r && ispSet_r;
      end
   end

   assign userSp = usp_r;
   assign intSp = isp_r;

   // ========================================
   // NMI guard
   assign pinLow = ~debOut[ing_pkg::DEB_NMI];
   // enable while low counts as an edge
   assign nmiArm = nmiEn_r && pinLow;
   assign stopBlk = nmiArm;
   assign stopReq = modeWr && regReq.wdata[ing_pkg::MODE_STOP] && !stopBlk;
   assign stopBit = (pwr_r == ing_pkg::PWR_STOP) && !stopBlk;

   // Enable, unlock and pending NMI
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         nmiEn_r <= 1'b0;
         unlock_r <= 1'b0;
         nmiArmPrev_r <= 1'b0;
         nmiPend_r <= 1'b0;
      end else begin
         // set only, cleared by reset alone
         nmiEn_r <= nmiEn_r | (modeWr && unlock_r && regReq.wdata[ing_pkg::MODE_NMIEN]);
         if (regReq.wr) begin
            unlock_r <= protWr && regReq.wdata[ing_pkg::PROT_UNLOCK];
         end
         nmiArmPrev_r <= nmiArm;
         nmiPend_r <= (nmiArm && !nmiArmPrev_r) || (nmiPend_r && !nmiAck);
      end
   end

   assign nmiReq = nmiPend_r;

   // ========================================
   // Other software-written settings
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wpcs_r <= 1'b0;
         mainClk_r <= 1'b0;
         srcSel_r <= '0;
         nDeb_r <= ing_pkg::DEB_RST;
         e5Deb_r <= ing_pkg::DEB_RST;
      end else begin
         if (modeWr) begin
            wpcs_r <= regReq.wdata[ing_pkg::MODE_WPCS];
            mainClk_r <= regReq.wdata[ing_pkg::MODE_MAINCLK];
         end
         if (regReq.wr && hit(regReq.addr, ing_pkg::ADDR_SRCSEL)) begin
            srcSel_r <= regReq.wdata[ing_pkg::NSRC-1:0];
         end
         if (regReq.wr && hit(regReq.addr, ing_pkg::ADDR_NDEB)) begin
            nDeb_r <= regReq.wdata[ing_pkg::DEB_W-1:0];
         end
         if (regReq.wr && hit(regReq.addr, ing_pkg::ADDR_E5DEB)) begin
            e5Deb_r <= regReq.wdata[ing_pkg::DEB_W-1:0];
         end
      end
   end

   // ========================================
   // Power state
   assign wake = intReq_r || nmiPend_r;

   always_comb begin
      pwr_nxt = pwr_r;
      unique case (pwr_r)
         ing_pkg::PWR_RUN: begin
            if (stopReq) begin
               pwr_nxt = ing_pkg::PWR_STOP;
            end else if (waitEnter) begin
               pwr_nxt = ing_pkg::PWR_WAIT;
            end
         end
         ing_pkg::PWR_WAIT: begin
            if (wake) begin
               pwr_nxt = ing_pkg::PWR_RUN;
            end
         end
         ing_pkg::PWR_STOP: begin
            if (wake) begin
               pwr_nxt = ing_pkg::PWR_RUN;
            end
         end
         default: pwr_nxt = ing_pkg::PWR_RUN;
      endcase
   end

   // State register and NMI stall in wait
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pwr_r <= ing_pkg::PWR_RUN;
         nmiStall_r <= 1'b0;
      end else begin
         pwr_r <= pwr_nxt;
         // stall in wait, set beats the clearing request
         if ((pwr_r == ing_pkg::PWR_WAIT) && nmiArm) begin
            nmiStall_r <= 1'b1;
         end else if (intReq_r) begin
            nmiStall_r <= 1'b0;
         end
      end
   end

   // CPU and peripheral clock gating
   assign cpuHalt = (pwr_r != ing_pkg::PWR_RUN) || nmiStall_r;
   assign cpuClkEn = pwr_r != ing_pkg::PWR_STOP;
   assign periphClkEn = (pwr_r == ing_pkg::PWR_RUN) || ((pwr_r == ing_pkg::PWR_WAIT) && !wpcs_r);
   assign subPeriphClkEn = pwr_r != ing_pkg::PWR_STOP;
   assign onChipClkSel = !mainClk_r;

   // ========================================
   // Read data, valid in the cycle after the strobe
   always_comb begin
      rdNxt = '0;
      case (regReq.addr)
         ing_pkg::ADDR_VEC: rdNxt[ing_pkg::VEC_W-1:0] = vec_r;
         ing_pkg::ADDR_MODE: begin
            rdNxt[ing_pkg::MODE_NMIEN] = nmiEn_r;
            rdNxt[ing_pkg::MODE_STOP] = stopBit;
            rdNxt[ing_pkg::MODE_WPCS] = wpcs_r;
            rdNxt[ing_pkg::MODE_MAINCLK] = mainClk_r;
         end
         ing_pkg::ADDR_PROT: rdNxt[ing_pkg::PROT_UNLOCK] = unlock_r;
         // raw pin level in bit five
         ing_pkg::ADDR_PORT8: rdNxt[ing_pkg::PORT8_BIT5] = nmiPin_b;
         ing_pkg::ADDR_SRCSEL: rdNxt[ing_pkg::NSRC-1:0] = srcSel_r;
         ing_pkg::ADDR_NDEB: rdNxt[ing_pkg::DEB_W-1:0] = nDeb_r;
         ing_pkg::ADDR_E5DEB: rdNxt[ing_pkg::DEB_W-1:0] = e5Deb_r;
         ing_pkg::ADDR_USP: rdNxt = usp_r;
         ing_pkg::ADDR_ISP: rdNxt = isp_r;
         default: begin
            if (icrBlk) begin
               rdNxt[ing_pkg::ICR_W-1:0] = icr_r[regReq.addr[ing_pkg::IDXW-1:0]];
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_r <= '0;
      end else begin
         rdata_r <= regReq.rd ? rdNxt : '0;
      end
   end

   assign regRdata = rdata_r;

   // ========================================
   // Checks
   sequence sAccept;
      intAck && intReq_r && !hwSet[vec_r.num];
   endsequence

   sequence sStrayRead;
      vecRd && intReq_r && !hwSet[vec_r.num];
   endsequence

   AST_ACK_CLR: assert property (@(posedge clk) disable iff (!rst_b)
      sAccept |=> !pendVec[$past(vec_r.num)])
      else $error("accepted request flag not cleared");

   AST_RD_CLR: assert property (@(posedge clk) disable iff (!rst_b)
      sStrayRead |=> !pendVec[$past(vec_r.num)])
      else $error("vector read did not clear flag");

   AST_SP_GATE: assert property (@(posedge clk) disable iff (!rst_b)
      !(uspSet_r && ispSet_r) |=> ##1 !intReq_r)
      else $error("request before stack pointers loaded");

   AST_NMI_ONEWAY: assert property (@(posedge clk) disable iff (!rst_b)
      nmiEn_r |=> nmiEn_r [*8])
      else $error("nmi enable dropped without reset");

   AST_NMI_IMM: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(nmiEn_r) && pinLow |=> nmiReq)
      else $error("enable while low gave no nmi");

   AST_PORT8: assert property (@(posedge clk) disable iff (!rst_b)
      regReq.rd && hit(regReq.addr, ing_pkg::ADDR_PORT8)
      |=> regRdata[ing_pkg::PORT8_BIT5] == $past(nmiPin_b))
      else $error("port bit five does not show nmi pin");

   AST_STOP_BLK: assert property (@(posedge clk) disable iff (!rst_b)
      modeWr && regReq.wdata[ing_pkg::MODE_STOP] && stopBlk && pwr_r == ing_pkg::PWR_RUN
      |=> pwr_r != ing_pkg::PWR_STOP)
      else $error("stop entered with nmi pin low");

   AST_UNLOCK: assert property (@(posedge clk) disable iff (!rst_b)
      unlock_r && regReq.wr && !protWr |=> !unlock_r)
      else $error("unlock survived a write");

   AST_WAIT_HALT: assert property (@(posedge clk) disable iff (!rst_b)
      pwr_r == ing_pkg::PWR_WAIT && nmiArm && !intReq_r |=> cpuHalt && cpuClkEn)
      else $error("nmi low in wait did not halt");

   AST_WPCS: assert property (@(posedge clk) disable iff (!rst_b)
      wpcs_r && pwr_r == ing_pkg::PWR_WAIT
      |-> !periphClkEn && subPeriphClkEn)
      else $error("wait clock gating wrong");
endmodule

// >>> include/ing_pkg.sv
// Constants, field layouts and carrier types of the interrupt and NMI guard
package ing_pkg;
   // ========================================
   // Widths
   localparam int NSRC = 8;
   localparam int AW = 5;
   localparam int DW = 16;
   localparam int IDXW = 3;
   localparam int LVLW = 3;
   localparam int ICR_W = 5;
   localparam int VEC_W = 6;
   localparam int DEB_W = 8;
   localparam int NDEB = 2;

   // ========================================
   // Register addresses
   localparam logic [AW-1:0] ADDR_ICR0 = 5'h00;
   localparam logic [AW-1:0] ADDR_VEC = 5'h10;
   localparam logic [AW-1:0] ADDR_MODE = 5'h11;
   localparam logic [AW-1:0] ADDR_PROT = 5'h12;
   localparam logic [AW-1:0] ADDR_PORT8 = 5'h13;
   localparam logic [AW-1:0] ADDR_SRCSEL = 5'h14;
   localparam logic [AW-1:0] ADDR_NDEB = 5'h15;
   localparam logic [AW-1:0] ADDR_E5DEB = 5'h16;
   localparam logic [AW-1:0] ADDR_USP = 5'h18;
   localparam logic [AW-1:0] ADDR_ISP = 5'h19;

   // ========================================
   // Field positions
   localparam int MODE_NMIEN = 0;
   localparam int MODE_STOP = 1;
   localparam int MODE_WPCS = 2;
   localparam int MODE_MAINCLK = 3;
   localparam int PROT_UNLOCK = 0;
   localparam int PORT8_BIT5 = 5;
   localparam int ICR_PEND = 3;
   localparam int EXT5_IDX = 5;
   localparam int DEB_NMI = 0;
   localparam int DEB_EXT5 = 1;

   // ========================================
   // Reset and special values
   localparam logic [DEB_W-1:0] DEB_BYPASS = 8'hff;
   localparam logic [DEB_W-1:0] DEB_RST = 8'h00;
   localparam logic [DEB_W-1:0] DEB_ONE = 8'h01;
   localparam logic [DW-1:0] SP_RST = 16'h0000;
   localparam logic [LVLW-1:0] LVL_OFF = 3'h0;
   localparam logic PIN_IDLE = 1'b1;

   // ========================================
   // Carriers
   typedef struct packed {
      logic trigger_polarity_bit;
      logic pend;
      logic [LVLW-1:0] level;
   } ing_icr_s;

   typedef struct packed {
      logic [IDXW-1:0] num;
      logic [LVLW-1:0] level;
   } ing_vec_s;

   typedef struct packed {
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
      logic wr;
      logic rd;
   } ing_bus_s;

   localparam ing_icr_s ICR_RST = 5'h00;
   localparam ing_vec_s VEC_RST = 6'h00;

   typedef enum logic [2:0] {
      PWR_RUN = 3'b001,
      PWR_WAIT = 3'b010,
      PWR_STOP = 3'b100
   } ing_pwr_e;
endpackage

// >>> rtl/ing_debounce.sv
// Digital debounce filter for one request pin
`timescale 1ns/1ps
module ing_debounce (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Pin and filter setting
   input wire logic pinIn,
   input wire logic [ing_pkg::DEB_W-1:0] filtVal,
   // Filtered level
   output logic pinOut
);
   logic filt_r;
   logic [ing_pkg::DEB_W-1:0] cnt_r;
   logic differs;
   logic settled;
   logic bypass;

   // ========================================
   // Filter decisions
   assign differs = pinIn != filt_r;
   assign settled = cnt_r >= filtVal;
   assign bypass = filtVal == ing_pkg::DEB_BYPASS;
   assign pinOut = bypass ? pinIn : filt_r;

   // Count stable samples before the level is taken
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         filt_r <= ing_pkg::PIN_IDLE;
         cnt_r <= ing_pkg::DEB_RST;
      end else if (!differs) begin
         cnt_r <= ing_pkg::DEB_RST;
      end else if (settled) begin
         filt_r <= pinIn;
         cnt_r <= ing_pkg::DEB_RST;
      end else begin
         cnt_r <= cnt_r + ing_pkg::DEB_ONE;
      end
   end
endmodule

// >>> verif/ing_cpu_model.sv
// Behavioural CPU core and NMI pin source facing the guard
`timescale 1ns/1ps
module ing_cpu_model #(
   parameter int HOLD_CYC = 62
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Requests from the guard
   input wire logic intReq,
   input wire logic nmiReq,
   // Bench controls
   input wire logic ackOn,
   input wire logic pinGoal,
   // Toward the guard
   output logic intAck,
   output logic nmiAck,
   output logic nmiPin_b
);
   int gap;
   int held;

   // ========================================
   // Acceptance, with a rest so a stale vector is never taken
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         intAck <= 1'b0;
         nmiAck <= 1'b0;
         gap <= 0;
      end else begin
         intAck <= 1'b0;
         nmiAck <= 1'b0;
         if (gap > 0) begin
            gap <= gap - 1;
         end else if (ackOn && nmiReq) begin
            nmiAck <= 1'b1;
            gap <= 3;
         end else if (ackOn && intReq) begin
            intAck <= 1'b1;
            gap <= 3;
         end
      end
   end

   // ========================================
   // NMI pin source
   // three clocks plus 300 ns per level
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         nmiPin_b <= 1'b1;
         held <= 0;
      end else if (pinGoal != nmiPin_b && held >= HOLD_CYC) begin
         nmiPin_b <= pinGoal;
         held <= 0;
      end else if (held < HOLD_CYC) begin
         held <= held + 1;
      end
   end
endmodule

// >>> verif/tb_ing_guard.sv
// Self-checking bench for the interrupt and NMI guard
`timescale 1ns/1ps
module tb_ing_guard;
   // ========================================
   // Signals
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   ing_pkg::ing_bus_s regReq = '0;
   logic [7:0] srcA = 8'hff;
   logic [7:0] srcB = 8'hff;
   logic waitEnter = 1'b0;
   logic ackOn = 1'b0;
   logic pinGoal = 1'b1;
   logic nmiPin_b, intAck, nmiAck, intReq, nmiReq, cpuHalt;
   logic cpuClkEn, periphClkEn, subPeriphClkEn, onChipClkSel;
   logic [15:0] regRdata, userSp, intSp;
   ing_pkg::ing_vec_s intVec;
   int failures = 0;
   int checks_done = 0;

   always #2.5 clk = ~clk;

   ing_guard dut (.clk(clk), .rst_b(rst_b), .regReq(regReq), .regRdata(regRdata),
      .srcA(srcA), .srcB(srcB), .nmiPin_b(nmiPin_b), .intAck(intAck), .nmiAck(nmiAck),
      .waitEnter(waitEnter), .intReq(intReq), .intVec(intVec), .nmiReq(nmiReq),
      .cpuHalt(cpuHalt), .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn),
      .subPeriphClkEn(subPeriphClkEn), .onChipClkSel(onChipClkSel), .userSp(userSp),
      .intSp(intSp));

   ing_cpu_model cpu (.clk(clk), .rst_b(rst_b), .intReq(intReq), .nmiReq(nmiReq),
      .ackOn(ackOn), .pinGoal(pinGoal), .intAck(intAck), .nmiAck(nmiAck),
      .nmiPin_b(nmiPin_b));

   // ========================================
   // Tasks
   task automatic ck(input logic [15:0] g, input logic [15:0] e);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("Error at %0t ns: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      regReq <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      regReq <= '0;
   endtask

   task automatic rc(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
      @(posedge clk);
      regReq <= '{a, 16'h0000, 1'b0, 1'b1};
      @(posedge clk);
      regReq <= '0;
      @(negedge clk);
      ck(regRdata & m, e);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic pin(input logic v);
      @(posedge clk);
      pinGoal <= v;
      cyc(140);
   endtask

   task automatic pulseWait();
      @(posedge clk);
      waitEnter <= 1'b1;
      @(posedge clk);
      waitEnter <= 1'b0;
   endtask

   task automatic give_verdict();
      if (failures == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Watchdog
   initial begin
      repeat (6000) @(posedge clk);
      failures++;
      give_verdict();
   end

   // ========================================
   // Tests
   initial begin
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      rc(ing_pkg::ADDR_USP, 16'hffff, 16'h0000);
      rc(ing_pkg::ADDR_ISP, 16'hffff, 16'h0000);
      rc(ing_pkg::ADDR_MODE, 16'h0001, 16'h0000);
      rc(ing_pkg::ADDR_PORT8, 16'h0020, 16'h0020);
      // Two sources pending before the stack pointers are loaded
      wr(5'h01, 16'h0002);
      wr(5'h02, 16'h0005);
      @(posedge clk);
      srcA <= 8'hf9;
      cyc(4);
      ck({15'h0, intReq}, 16'h0000);
      wr(ing_pkg::ADDR_USP, 16'h0400);
      wr(ing_pkg::ADDR_ISP, 16'h0500);
      cyc(3);
      ck({15'h0, intReq}, 16'h0001);
      ck(userSp, 16'h0400);
      ck(intSp, 16'h0500);
      ck({10'h0, intVec}, 16'h0015);
      rc(ing_pkg::ADDR_VEC, 16'h003f, 16'h0015);
      rc(5'h02, 16'h0008, 16'h0000);
      rc(5'h01, 16'h0008, 16'h0008);
      ackOn <= 1'b1;
      cyc(8);
      ackOn <= 1'b0;
      rc(5'h01, 16'h0008, 16'h0000);
      ck({15'h0, intReq}, 16'h0000);
      // Polarity and source select changes, then plain clears
      wr(5'h03, 16'h0013);
      cyc(2);
      wr(5'h03, 16'h0013);
      cyc(2);
      rc(5'h03, 16'h0008, 16'h0000);
      wr(ing_pkg::ADDR_SRCSEL, 16'h0002);
      wr(5'h01, 16'h0002);
      @(posedge clk);
      srcB <= 8'hfd;
      cyc(3);
      rc(5'h01, 16'h0008, 16'h0008);
      // Level change that keeps the pending bit written as one
      wr(5'h01, 16'h000b);
      rc(5'h01, 16'h000f, 16'h000b);
      wr(5'h01, 16'h0002);
      // Unlock spent on an unmapped write
      wr(ing_pkg::ADDR_MODE, 16'h0001);
      rc(ing_pkg::ADDR_MODE, 16'h0001, 16'h0000);
      wr(ing_pkg::ADDR_PROT, 16'h0001);
      wr(5'h1f, 16'h0000);
      wr(ing_pkg::ADDR_MODE, 16'h0001);
      rc(ing_pkg::ADDR_MODE, 16'h0001, 16'h0000);
      rc(ing_pkg::ADDR_PROT, 16'h0001, 16'h0000);
      // Enable while the pin is low
      pin(1'b0);
      rc(ing_pkg::ADDR_PORT8, 16'h0020, 16'h0000);
      ck({15'h0, nmiReq}, 16'h0000);
      wr(ing_pkg::ADDR_PROT, 16'h0001);
      wr(ing_pkg::ADDR_MODE, 16'h0001);
      cyc(2);
      ck({15'h0, nmiReq}, 16'h0001);
      wr(ing_pkg::ADDR_MODE, 16'h0003);
      rc(ing_pkg::ADDR_MODE, 16'h0002, 16'h0000);
      ck({15'h0, cpuClkEn}, 16'h0001);
      wr(ing_pkg::ADDR_PROT, 16'h0001);
      wr(ing_pkg::ADDR_MODE, 16'h0000);
      rc(ing_pkg::ADDR_MODE, 16'h0001, 16'h0001);
      ackOn <= 1'b1;
      cyc(4);
      ackOn <= 1'b0;
      ck({15'h0, nmiReq}, 16'h0000);
      // Pin falls in wait mode, a later request resumes
      pin(1'b1);
      pulseWait();
      pin(1'b0);
      ck({15'h0, cpuHalt}, 16'h0001);
      ck({15'h0, cpuClkEn}, 16'h0001);
      wr(5'h04, 16'h0001);
      @(posedge clk);
      srcA <= 8'he9;
      cyc(4);
      ck({15'h0, cpuHalt}, 16'h0000);
      ackOn <= 1'b1;
      cyc(12);
      ackOn <= 1'b0;
      // Peripheral clocks gated in wait, sub-clock one kept
      wr(ing_pkg::ADDR_MODE, 16'h0004);
      pulseWait();
      cyc(1);
      ck({15'h0, periphClkEn}, 16'h0000);
      ck({15'h0, subPeriphClkEn}, 16'h0001);
      // source six stands for a timer wake with pulse output off
      wr(5'h06, 16'h0001);
      @(posedge clk);
      srcA <= 8'ha9;
      cyc(4);
      ck({15'h0, periphClkEn}, 16'h0001);
      ackOn <= 1'b1;
      cyc(8);
      ackOn <= 1'b0;
      // Stop on the main clock, left by hardware reset
      pin(1'b1);
      wr(ing_pkg::ADDR_NDEB, 16'h00ff);
      wr(ing_pkg::ADDR_E5DEB, 16'h00ff);
      rc(ing_pkg::ADDR_NDEB, 16'h00ff, 16'h00ff);
      rc(ing_pkg::ADDR_E5DEB, 16'h00ff, 16'h00ff);
      wr(ing_pkg::ADDR_MODE, 16'h000a);
      cyc(2);
      ck({15'h0, cpuClkEn}, 16'h0000);
      ck({15'h0, onChipClkSel}, 16'h0000);
      @(posedge clk);
      rst_b <= 1'b0;
      cyc(2);
      @(posedge clk);
      rst_b <= 1'b1;
      cyc(1);
      ck({15'h0, onChipClkSel}, 16'h0001);
      ck({15'h0, cpuClkEn}, 16'h0001);
      ck(userSp, 16'h0000);
      ck(intSp, 16'h0000);
      rc(ing_pkg::ADDR_MODE, 16'h0001, 16'h0000);
      give_verdict();
   end
endmodule
